// *** hw/rtc_block.sv ***
// Real-time clock top: Avalon-MM register slave, pointer windows, alarm, pin.
// Assumes nrst is power-on reset and master_clear_n an unsynchronised pin.
`timescale 1ns/1ns
`default_nettype none
module rtc_block
	import rtc_pkg::*;
(
	// Clock and power-on reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Device pins
	input  wire logic        master_clear_n,
	input  wire logic        xtal_in,
	output logic             clock_pin,
	output logic             clock_pin_oe,
	output logic             alarm_event,
	// Avalon-MM slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest
);
	import rtc_pkg::*;

	// ==========================================
	// State
	logic        clock_run_enable, next_run;
	logic        value_write_unlock, next_unlock;
	logic        clock_pin_output_enable, next_oe;
	logic [1:0]  time_window_pointer, next_tptr;
	logic [7:0]  trim, next_trim;
	alarm_cfg_t  alarm_config_register, next_acfg;
	cal_t        alarm_value, next_alarm_value;
	logic        pin_source_select, next_psel;
	logic        alarm_toggle, next_toggle;
	logic        next_alarm_event;
	logic        done, next_done;
	logic [31:0] next_rdata;
	logic [1:0]  master_clear_pin_sync;
	logic        tick_d, half_d;

	// ==========================================
	// Submodules
	cal_t        time_now;
	cal_t        time_load_value;
	logic        time_load;
	logic        sec_tick;
	logic        half_second_flag;
	logic        rollover_imminent_flag;
	logic        restart_half;

	xtal_prescaler u_prescaler (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.xtal_in      (xtal_in),
		.run          (clock_run_enable),
		.restart      (restart_half),
		.minute_start (time_now.sec == 8'h00),
		.trim         (trim),
		.tick         (sec_tick),
		.half_flag    (half_second_flag),
		.near_roll    (rollover_imminent_flag)
	);

	calendar_counter u_calendar (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.tick       (sec_tick),
		.load       (time_load),
		.load_value (time_load_value),
		.now        (time_now)
	);

	// ==========================================
	// Bus decode
	logic        req, commit, high_be, low_be;
	logic        hit_cfg, hit_time, hit_acfg, hit_awin, hit_pad;
	logic [15:0] wd;
	logic [15:0] config_view;
	logic        master_clear_pin_active;
	logic        alarm_fire, match;
	logic        eq_s, eq_m, eq_h, eq_w, eq_d, eq_mo;

	assign req = read | write;
	assign waitrequest = req & ~done;
	assign commit = req & done;
	assign high_be = byteenable[1];
	assign low_be = byteenable[0];
	assign wd = writedata[15:0];
	assign hit_cfg = address[4:2] == OFS_CONFIG[4:2];
	assign hit_time = address[4:2] == OFS_TIME_WIN[4:2];
	assign hit_acfg = address[4:2] == OFS_ALARM_CFG[4:2];
	assign hit_awin = address[4:2] == OFS_ALARM_WIN[4:2];
	assign hit_pad = address[4:2] == OFS_PAD_CFG[4:2];
	assign master_clear_pin_active = ~master_clear_pin_sync[1];

	always_comb
	begin
		config_view = 16'h0000;
		config_view[BIT_RUN_ENABLE] = clock_run_enable;
		config_view[BIT_WRITE_UNLOCK] = value_write_unlock;
		config_view[BIT_ROLLOVER] = rollover_imminent_flag;
		config_view[BIT_HALF_SECOND] = half_second_flag;
		config_view[BIT_PIN_OE] = clock_pin_output_enable;
		config_view[9:8] = time_window_pointer;
		config_view[7:0] = trim;
	end

	// ==========================================
	// Alarm compare
	always_comb
	begin
		eq_s = time_now.sec == alarm_value.sec;
		eq_m = time_now.min == alarm_value.min;
		eq_h = time_now.hour == alarm_value.hour;
		eq_w = time_now.wday == alarm_value.wday;
		eq_d = time_now.day == alarm_value.day;
		eq_mo = time_now.month == alarm_value.month;
		case (alarm_config_register.interval)
			4'h1: match = 1'b1;
			4'h2: match = time_now.sec[3:0] == alarm_value.sec[3:0];
			4'h3: match = eq_s;
			4'h4: match = eq_s & (time_now.min[3:0] == alarm_value.min[3:0]);
			4'h5: match = eq_s & eq_m;
			4'h6: match = eq_s & eq_m & eq_h;
			4'h7: match = eq_s & eq_m & eq_h & eq_w;
			4'h8: match = eq_s & eq_m & eq_h & eq_d;
			LAST_INTERVAL: match = eq_s & eq_m & eq_h & eq_d & eq_mo;
			default: match = 1'b0;
		endcase
		if (alarm_config_register.interval == 4'h0)
			alarm_fire = tick_d | (half_second_flag & ~half_d);
		else
			alarm_fire = tick_d & match;
		alarm_fire = alarm_fire & alarm_config_register.arm;
	end

	// ==========================================
	// Next-state of registers
	always_comb
	begin
		next_done = req & ~done;
		next_rdata = readdata;
		next_run = clock_run_enable;
		next_unlock = value_write_unlock;
		next_oe = clock_pin_output_enable;
		next_tptr = time_window_pointer;
		next_trim = trim;
		next_acfg = alarm_config_register;
		next_alarm_value = alarm_value;
		next_psel = pin_source_select;
		next_toggle = alarm_toggle;
		next_alarm_event = alarm_fire;
		time_load = 1'b0;
		time_load_value = put_pair(time_now, time_window_pointer, wd, byteenable[1:0]);
		restart_half = 1'b0;

		// Hardware alarm events first, software writes override
		if (alarm_fire)
		begin
			next_toggle = ~alarm_toggle;
			if (alarm_config_register.repeat_count != 8'h00 || alarm_config_register.wrap)
				next_acfg.repeat_count = alarm_config_register.repeat_count - 8'h01;
			else
				next_acfg.arm = 1'b0;
		end

		if (req && !done)
		begin
			next_rdata = 32'h00000000;
			if (hit_cfg)
				next_rdata[15:0] = config_view;
			else if (hit_time)
				next_rdata[15:0] = get_pair(time_now, time_window_pointer);
			else if (hit_acfg)
				next_rdata[15:0] = alarm_config_register;
			else if (hit_awin)
				next_rdata[15:0] = get_pair(alarm_value, alarm_config_register.ptr);
			else if (hit_pad)
				next_rdata[BIT_PIN_SOURCE] = pin_source_select;
		end

		if (commit && write && hit_cfg)
		begin
			if (high_be)
			begin
				if (value_write_unlock)
					next_run = wd[BIT_RUN_ENABLE];
				next_unlock = wd[BIT_WRITE_UNLOCK];
				next_oe = wd[BIT_PIN_OE];
				next_tptr = wd[9:8];
			end
			if (low_be)
				next_trim = wd[7:0];
		end

		if (commit && hit_time && (read || high_be) && time_window_pointer != 2'b00)
			next_tptr = time_window_pointer - 2'b01;

		if (commit && write && hit_time && value_write_unlock && (high_be || low_be))
		begin
			time_load = 1'b1;
			if (time_window_pointer == 2'b00 && low_be)
				restart_half = 1'b1;
		end

		if (commit && write && hit_acfg)
		begin
			if (high_be)
			begin
				next_acfg.arm = wd[BIT_ALARM_ARM];
				next_acfg.wrap = wd[BIT_REPEAT_WRAP];
				next_acfg.interval = wd[13:10];
				next_acfg.ptr = wd[9:8];
			end
			if (low_be)
				next_acfg.repeat_count = wd[7:0];
		end

		if (commit && write && hit_awin)
			next_alarm_value = put_pair(alarm_value, alarm_config_register.ptr, wd, byteenable[1:0]);

		if (commit && hit_awin && (read || high_be) && alarm_config_register.ptr != 2'b00)
			next_acfg.ptr = alarm_config_register.ptr - 2'b01;

		if (commit && write && hit_pad && low_be)
			next_psel = wd[BIT_PIN_SOURCE];
	end

	// ==========================================
	// Power-on only state
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			clock_run_enable <= CONFIG_RESET[BIT_RUN_ENABLE];
			value_write_unlock <= CONFIG_RESET[BIT_WRITE_UNLOCK];
			clock_pin_output_enable <= CONFIG_RESET[BIT_PIN_OE];
			time_window_pointer <= CONFIG_RESET[9:8];
			trim <= CONFIG_RESET[7:0];
			master_clear_pin_sync <= 2'b11;
			done <= 1'b0;
			readdata <= 32'h00000000;
			tick_d <= 1'b0;
			half_d <= 1'b0;
		end
		else
		begin
			clock_run_enable <= next_run;
			value_write_unlock <= next_unlock;
			clock_pin_output_enable <= next_oe;
			time_window_pointer <= next_tptr;
			trim <= next_trim;
			master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_n};
			done <= next_done;
			readdata <= next_rdata;
			tick_d <= sec_tick;
			half_d <= half_second_flag;
		end
	end

	// ==========================================
	// State also cleared by master clear
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alarm_config_register <= ALARM_RESET;
			alarm_value <= CAL_RESET;
			pin_source_select <= 1'b0;
			alarm_toggle <= 1'b0;
			alarm_event <= 1'b0;
		end
		else if (master_clear_pin_active)
		begin
			alarm_config_register <= ALARM_RESET;
			alarm_value <= CAL_RESET;
			pin_source_select <= 1'b0;
			alarm_toggle <= 1'b0;
			alarm_event <= 1'b0;
		end
		else
		begin
			alarm_config_register <= next_acfg;
			alarm_value <= next_alarm_value;
			pin_source_select <= next_psel;
			alarm_toggle <= next_toggle;
			alarm_event <= next_alarm_event;
		end
	end

	// ==========================================
	// Clock pin
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			clock_pin <= 1'b0;
			clock_pin_oe <= 1'b0;
		end
		else
		begin
			clock_pin <= next_oe & (pin_source_select ? half_second_flag : alarm_toggle);
			clock_pin_oe <= next_oe;
		end
	end
endmodule : rtc_block
`default_nettype wire

// *** hw/rtc_pkg.sv ***
// Shared constants, register layout and calendar helpers for the clock block.
// Assumes a 100 MHz core clock and a slow crystal sampled as a plain pin.
package rtc_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [4:0] OFS_CONFIG     = 5'h00;
	localparam logic [4:0] OFS_TIME_WIN   = 5'h04;
	localparam logic [4:0] OFS_ALARM_CFG  = 5'h08;
	localparam logic [4:0] OFS_ALARM_WIN  = 5'h0c;
	localparam logic [4:0] OFS_PAD_CFG    = 5'h10;

	// ==========================================
	// Field positions
	localparam int BIT_RUN_ENABLE   = 15;
	localparam int BIT_WRITE_UNLOCK = 13;
	localparam int BIT_ROLLOVER     = 12;
	localparam int BIT_HALF_SECOND  = 11;
	localparam int BIT_PIN_OE       = 10;
	localparam int BIT_ALARM_ARM    = 15;
	localparam int BIT_REPEAT_WRAP  = 14;
	localparam int BIT_PIN_SOURCE   = 1;

	// ==========================================
	// Reset values and timing
	localparam logic [15:0] CONFIG_RESET  = 16'h0000;
	localparam logic [15:0] ALARM_RESET   = 16'h0000;
	localparam int          XTAL_PER_SEC  = 32768;
	localparam int          IMMINENT_EDGE = 32;
	localparam int          TRIM_STEP     = 4;
	localparam logic [3:0]  LAST_INTERVAL = 4'h9;

	// ==========================================
	// Calendar value, one BCD byte per field
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} cal_t;

	localparam cal_t CAL_RESET = '{year: 8'h00, month: 8'h01, day: 8'h01, wday: 8'h00,
		hour: 8'h00, min: 8'h00, sec: 8'h00};

	// Alarm configuration fields
	typedef struct packed {
		logic       arm;
		logic       wrap;
		logic [3:0] interval;
		logic [1:0] ptr;
		logic [7:0] repeat_count;
	} alarm_cfg_t;

	// ==========================================
	// Helpers
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// Window view of a pair, unused bits read zero
	function automatic logic [15:0] get_pair(input cal_t c, input logic [1:0] p);
		case (p)
			2'b00: return {1'b0, c.min[6:0], 1'b0, c.sec[6:0]};
			2'b01: return {5'h00, c.wday[2:0], 2'b00, c.hour[5:0]};
			2'b10: return {3'h0, c.month[4:0], 2'b00, c.day[5:0]};
			default: return {8'h00, c.year};
		endcase
	endfunction : get_pair

	function automatic cal_t put_pair(input cal_t c, input logic [1:0] p,
		input logic [15:0] d, input logic [1:0] be);
		cal_t r;
		r = c;
		case (p)
			2'b00:
			begin
				if (be[1]) r.min = {1'b0, d[14:8]};
				if (be[0]) r.sec = {1'b0, d[6:0]};
			end
			2'b01:
			begin
				if (be[1]) r.wday = {5'h00, d[10:8]};
				if (be[0]) r.hour = {2'b00, d[5:0]};
			end
			2'b10:
			begin
				if (be[1]) r.month = {3'h0, d[12:8]};
				if (be[0]) r.day = {2'b00, d[5:0]};
			end
			default:
			begin
				if (be[0]) r.year = d[7:0];
			end
		endcase
		return r;
	endfunction : put_pair

endpackage : rtc_pkg

// *** hw/xtal_prescaler.sv ***
// Crystal edge counter giving the seconds tick, half-second and rollover flags.
// Assumes the crystal is far slower than core_clk and arrives unsynchronised.
`timescale 1ns/1ns
`default_nettype none
module xtal_prescaler
	import rtc_pkg::*;
#(
	parameter int PER_SEC = XTAL_PER_SEC
)(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Crystal pin and control
	input  wire logic       xtal_in,
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic       minute_start,
	input  wire logic [7:0] trim,
	// Status
	output logic            tick,
	output logic            half_flag,
	output logic            near_roll
);
	import rtc_pkg::*;

	logic [2:0]  sync, next_sync;
	logic [17:0] count, next_count;
	logic        next_tick;
	logic [17:0] adj;
	logic [17:0] limit;
	logic        edge_seen;

	always_comb
	begin
		next_sync = {sync[1:0], xtal_in};
		edge_seen = sync[1] & ~sync[2];
		adj = minute_start ? {{8{trim[7]}}, trim, 2'b00} : 18'h00000;
		limit = 18'(PER_SEC) - adj;
		next_count = count;
		next_tick = 1'b0;
		if (restart)
			next_count = 18'h00000;
		else if (run && edge_seen)
		begin
			if (count + 18'h00001 >= limit)
			begin
				next_count = 18'h00000;
				next_tick = 1'b1;
			end
			else
				next_count = count + 18'h00001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync <= 3'b000;
			count <= 18'h00000;
			tick <= 1'b0;
		end
		else
		begin
			sync <= next_sync;
			count <= next_count;
			tick <= next_tick;
		end
	end

	assign half_flag = count >= 18'(PER_SEC / 2);
	assign near_roll = run && (count + 18'(IMMINENT_EDGE) >= limit);
endmodule : xtal_prescaler
`default_nettype wire

// *** hw/calendar_counter.sv ***
// BCD time and calendar counter with software load.
// Assumes tick is a one-cycle pulse per second; load wins over tick.
`timescale 1ns/1ns
`default_nettype none
module calendar_counter
	import rtc_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         nrst,
	// Control
	input  wire logic         tick,
	input  wire logic         load,
	input  wire rtc_pkg::cal_t load_value,
	// Current value
	output rtc_pkg::cal_t     now
);
	import rtc_pkg::*;

	cal_t       next_now;
	logic [7:0] dim;
	logic       leap;
	logic       s_max, m_max, h_max, d_max, mo_max;

	always_comb
	begin
		leap = now.year[4] ? (now.year[3:0] == 4'h2 || now.year[3:0] == 4'h6)
			: (now.year[3:0] == 4'h0 || now.year[3:0] == 4'h4 || now.year[3:0] == 4'h8);
		case (now.month)
			8'h02: dim = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
			default: dim = 8'h31;
		endcase
		s_max = now.sec == 8'h59;
		m_max = now.min == 8'h59;
		h_max = now.hour == 8'h23;
		d_max = now.day == dim;
		mo_max = now.month == 8'h12;
		next_now = now;
		if (load)
			next_now = load_value;
		else if (tick)
		begin
			next_now.sec = s_max ? 8'h00 : bcd_inc(now.sec);
			if (s_max)
				next_now.min = m_max ? 8'h00 : bcd_inc(now.min);
			if (s_max && m_max)
				next_now.hour = h_max ? 8'h00 : bcd_inc(now.hour);
			if (s_max && m_max && h_max)
			begin
				next_now.wday = (now.wday == 8'h06) ? 8'h00 : bcd_inc(now.wday);
				next_now.day = d_max ? 8'h01 : bcd_inc(now.day);
				if (d_max)
					next_now.month = mo_max ? 8'h01 : bcd_inc(now.month);
				if (d_max && mo_max)
					next_now.year = (now.year == 8'h99) ? 8'h00 : bcd_inc(now.year);
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			now <= CAL_RESET;
		else
			now <= next_now;
	end
endmodule : calendar_counter
`default_nettype wire

// *** tb/rtc_chk.sv ***
// Port-level assertions for the clock block.
// Assumes binding onto rtc_block, one core clock domain.
`timescale 1ns/1ns
`default_nettype none
module rtc_chk (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Pins
	input  wire logic        master_clear_n,
	input  wire logic        clock_pin,
	input  wire logic        clock_pin_oe,
	input  wire logic        alarm_event,
	// Register bus
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest
);
	// ==========================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic rd_done = read && !waitrequest;

	property p_pin_gated; clock_pin |-> clock_pin_oe; endproperty
	a_pin_gated: assert property (p_pin_gated) else $error("pin high while disabled");
	property p_oe_por; $rose(nrst) |-> !clock_pin_oe && !clock_pin; endproperty
	a_oe_por: assert property (p_oe_por) else $error("pin enabled after power-on");
	property p_master_clear_pin_keep; !master_clear_n && !write |=> $stable(clock_pin_oe); endproperty
	a_master_clear_pin_keep: assert property (p_master_clear_pin_keep) else $error("master clear touched config");
	property p_pulse; alarm_event |=> !alarm_event; endproperty
	a_pulse: assert property (p_pulse) else $error("alarm pulse too long");
	property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
	property p_rd_hi; rd_done |-> readdata[31:16] == 16'h0000; endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
	property p_win_msb; rd_done && address[2] |-> readdata[15] == 1'b0; endproperty
	a_win_msb: assert property (p_win_msb) else $error("window bit 15 set");
	property p_roll_half; rd_done && address == 5'h00 && readdata[12] |-> readdata[11]; endproperty
	a_roll_half: assert property (p_roll_half) else $error("rollover outside second half");
	property p_oe_read; rd_done && address == 5'h00 |-> readdata[10] == clock_pin_oe; endproperty
	a_oe_read: assert property (p_oe_read) else $error("pin enable differs from config");
	c_roll: cover property (rd_done && address == 5'h00 && readdata[12]);
	c_alarm: cover property (alarm_event);
	c_master_clear_pin: cover property (!master_clear_n && clock_pin_oe);
endmodule : rtc_chk
bind rtc_block rtc_chk i_chk (.core_clk, .nrst, .master_clear_n, .clock_pin, .clock_pin_oe,
	.alarm_event, .address, .read, .write, .readdata, .waitrequest);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench with a register model of the clock block.
// Assumes rtc_pkg and rtc_block compiled first; bench drives the crystal.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import rtc_pkg::*;
	// ==========================================
	// Signals and model state
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        master_clear_n = 1'b1;
	logic        xtal_in = 1'b0;
	logic        xtal_go = 1'b0;
	logic [4:0]  address = 5'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [3:0]  byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest, clock_pin, clock_pin_oe, alarm_event;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          n_edge = 0;
	int          n_alarm = 0;
	int          e0;
	logic [31:0] seed = 32'habddde3b;
	logic [31:0] q;
	logic [15:0] m_cfg = 16'h0000;
	logic [15:0] m_acfg = 16'h0000;
	logic [15:0] m_win[2][4];
	localparam logic [15:0] PMASK[4] = '{16'h7f7f, 16'h073f, 16'h1f3f, 16'h00ff};
	localparam logic [15:0] WRESET[4] = '{16'h0000, 16'h0000, 16'h0101, 16'h0000};
	localparam int PERIOD0 = XTAL_PER_SEC - TRIM_STEP * 127;

	always #5 core_clk = ~core_clk;

	rtc_block i_dut (.core_clk, .nrst, .master_clear_n, .xtal_in, .clock_pin, .clock_pin_oe,
		.alarm_event, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest);

	// ==========================================
	// Crystal, counters and timeout
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (xtal_go)
			xtal_in <= ~xtal_in;
		if (xtal_go && !xtal_in)
			n_edge <= n_edge + 1;
		if (cyc == 100000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	always @(negedge core_clk)
		if (alarm_event === 1'b1)
			n_alarm++;

	// ==========================================
	// Tasks
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp

	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [1:0] be);
		logic wr;
		address <= a;
		writedata <= {16'h0000, d};
		byteenable <= {2'b00, be};
		read <= !w;
		write <= w;
		// Sample wait and data at the rising edge, before the slave updates
		do
		begin
			@(posedge core_clk);
			wr = waitrequest;
			q = readdata;
		end
		while (wr !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic rd_reg(input logic [4:0] a, input logic [15:0] e, input logic [15:0] mk);
		bus(1'b0, a, 16'h0000, 2'b11);
		cmp("register", e & mk, q[15:0] & mk);
	endtask : rd_reg

	task automatic wr_cfg(input logic [15:0] d);
		bus(1'b1, OFS_CONFIG, d, 2'b11);
		m_cfg = {m_cfg[13] ? d[15] : m_cfg[15], 1'b0, d[13], 2'b00, d[10:0]};
	endtask : wr_cfg

	task automatic wr_acfg(input logic [15:0] d);
		bus(1'b1, OFS_ALARM_CFG, d, 2'b11);
		m_acfg = d;
	endtask : wr_acfg

	task automatic dec(input int s);
		if (s == 0 && m_cfg[9:8] != 2'b00)
			m_cfg[9:8] = m_cfg[9:8] - 2'b01;
		if (s != 0 && m_acfg[9:8] != 2'b00)
			m_acfg[9:8] = m_acfg[9:8] - 2'b01;
	endtask : dec

	task automatic wr_win(input int s, input logic [15:0] d, input logic [1:0] be);
		logic [1:0]  p;
		logic [15:0] m;
		p = (s == 0) ? m_cfg[9:8] : m_acfg[9:8];
		m = PMASK[p] & {{8{be[1]}}, {8{be[0]}}};
		bus(1'b1, (s == 0) ? OFS_TIME_WIN : OFS_ALARM_WIN, d, be);
		if (s != 0 || m_cfg[13])
			m_win[s][p] = (m_win[s][p] & ~m) | (d & m);
		if (be[1])
			dec(s);
	endtask : wr_win

	task automatic rd_win(input int s);
		logic [1:0] p;
		p = (s == 0) ? m_cfg[9:8] : m_acfg[9:8];
		bus(1'b0, (s == 0) ? OFS_TIME_WIN : OFS_ALARM_WIN, 16'h0000, 2'b01);
		cmp("window", m_win[s][p], q[15:0]);
		dec(s);
	endtask : rd_win

	task automatic wait_edge(input int n);
		while (n_edge < n)
			@(posedge core_clk);
	endtask : wait_edge

	// ==========================================
	// Main sequence
	initial
	begin
		m_win[0] = WRESET;
		m_win[1] = WRESET;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd_reg(OFS_CONFIG, CONFIG_RESET, 16'hffff);
		rd_reg(OFS_ALARM_CFG, ALARM_RESET, 16'hffff);
		bus(1'b1, 5'h18, 16'hffff, 2'b11);
		rd_reg(5'h18, 16'h0000, 16'hffff);
		wr_cfg(16'ha300);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		repeat (5) rd_win(0);
		wr_cfg(16'h0300);
		seed = lfsr(seed);
		wr_win(0, seed[15:0], 2'b01);
		wr_win(0, seed[31:16], 2'b10);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		wr_cfg(16'h2300);
		for (int p = 0; p < 4; p++)
		begin
			seed = lfsr(seed);
			wr_win(0, seed[15:0], 2'b11);
		end
		wr_cfg(16'h2300);
		repeat (4) rd_win(0);
		wr_acfg(16'h0200);
		wr_win(1, seed[31:16], 2'b01);
		rd_reg(OFS_ALARM_CFG, m_acfg, 16'hffff);
		for (int p = 0; p < 3; p++)
		begin
			seed = lfsr(seed);
			wr_win(1, seed[15:0], 2'b11);
		end
		wr_acfg(16'h0200);
		repeat (4) rd_win(1);
		// Running second with full positive trim
		bus(1'b1, OFS_PAD_CFG, 16'h0002, 2'b11);
		rd_reg(OFS_PAD_CFG, 16'h0002, 16'h0002);
		wr_cfg(16'h2000);
		wr_win(0, 16'h0000, 2'b11);
		wr_cfg(16'ha47f);
		xtal_go <= 1'b1;
		wait_edge(16450);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		cmp("flags", 16'h0001, {14'h0, q[12:11]});
		@(negedge core_clk);
		cmp("pin", 16'h0003, {14'h0, clock_pin_oe, clock_pin});
		@(posedge core_clk);
		wr_win(0, 16'h0000, 2'b01);
		e0 = n_edge;
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		cmp("flags", 16'h0000, {14'h0, q[12:11]});
		master_clear_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		master_clear_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		m_acfg = 16'h0000;
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		rd_reg(OFS_ALARM_CFG, m_acfg, 16'hffff);
		rd_reg(OFS_PAD_CFG, 16'h0000, 16'h0002);
		wr_acfg(16'hc400);
		wait_edge(e0 + PERIOD0 - 100);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		cmp("flags", 16'h0001, {14'h0, q[12:11]});
		rd_win(0);
		wait_edge(e0 + PERIOD0 - 12);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		cmp("flags", 16'h0003, {14'h0, q[12:11]});
		wait_edge(e0 + PERIOD0 + 60);
		m_win[0][0] = 16'h0001;
		rd_win(0);
		rd_reg(OFS_CONFIG, m_cfg, 16'he7ff);
		cmp("flags", 16'h0000, {14'h0, q[12:11]});
		m_acfg = 16'hc4ff;
		rd_reg(OFS_ALARM_CFG, m_acfg, 16'hffff);
		cmp("alarms", 16'h0001, n_alarm[15:0]);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
